//--- test/asrp_host.sv
// asrp_host.sv: host side: clock pin resolution and rising-edge data sampler
// assumes the bench plays the host clock driver through host_oe and host_val
`timescale 1ns/100ps
module asrp_host (
    // pin drivers and sampler clear
    input  wire        cs_n, host_oe, host_val, ext_pu, sck_o, sck_oe_n, sck_pu, sdo, clr,
    // observed
    output wire        sck_pin,
    output reg  [23:0] rx,
    output reg  [4:0]  nbits
);
    // a released pin without any pull-up resolves low, which is what traps external mode
    assign sck_pin = !sck_oe_n ? sck_o : host_oe ? host_val : (sck_pu | ext_pu);
    // sample on rising edges while selected; first bit taken is the status flag
    always @(posedge sck_pin or posedge clr) begin
        if (clr) nbits <= 5'h00;
        else if (!cs_n) begin
            rx    <= {rx[22:0], sdo};
            nbits <= nbits + 5'h01;
        end
    end
endmodule // asrp_host

//--- test/asrp_port_tb.sv
// asrp_port_tb.sv: self-checking bench for the serial readout port
// assumes the host model resolves the clock pin; the bench plays core and host clock
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module asrp_port_tb;
    reg         clk = 1'b0, rst_n = 1'b0, por = 1'b0, done = 1'b0, cs_n = 1'b1, clr = 1'b0;
    reg         h_oe = 1'b1, h_val = 1'b0, pu = 1'b0;
    reg  [23:0] data = 24'h00_0000;
    reg  [7:0]  starts = 8'h00;
    integer     error_cnt = 0, check_count = 0;
    wire        start, sck_o, sck_oe_n, sck_pu, sdo, sdo_oe_n, sck_pin;
    wire [23:0] rx;
    wire [4:0]  nbits;
    always #5 clk = ~clk;
    always @(posedge clk) if (start) starts <= starts + 8'h01;
    asrp_port dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1), .POR_DONE_I(por),
        .RATE_SELECT_EXT_I(1'b0), .CONV_DONE_I(done), .CONV_DATA_I(data), .CONV_START_O(start),
        .CS_N_I(cs_n), .SCK_I(sck_pin), .SCK_O(sck_o), .SCK_OE_N_O(sck_oe_n), .SCK_PULLUP_O(sck_pu),
        .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n));
    asrp_host host_u (.cs_n(cs_n), .host_oe(h_oe), .host_val(h_val), .ext_pu(pu), .sck_o(sck_o),
        .sck_oe_n(sck_oe_n), .sck_pu(sck_pu), .sdo(sdo), .clr(clr), .sck_pin(sck_pin), .rx(rx), .nbits(nbits));
    task final_report; begin
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    end endtask
    task tick(input integer n); repeat (n) @(posedge clk); endtask
    task zap; begin clr <= 1'b1; tick(1); clr <= 1'b0; end endtask
    task core_done(input [23:0] d); begin data <= d; done <= 1'b1; tick(1); done <= 1'b0; end endtask
    // host clock at 160 ns: 8 reference cycles per half period
    task ext_clk(input integer n); repeat (n) begin h_val <= 1'b1; tick(8); h_val <= 1'b0; tick(8); end endtask
    task wait_bits(input [4:0] n); integer i; begin
        for (i = 0; i < 5000 && nbits !== n; i++) tick(1);
        if (i == 5000) begin error_cnt++; final_report; end
    end endtask
    // two-wire external clock: flag, load, frame, restart, extra edges refused
    task s_ext; reg [7:0] s0; begin
        cs_n <= 1'b0; tick(8);
        `CHK({sck_oe_n, sdo_oe_n, sdo}, 3'h5)
        core_done(24'hA5_C396); tick(6);
        `CHK(sdo, 1'b0)
        zap; s0 = starts; ext_clk(24); tick(6);
        `CHK(rx, 24'h52_E1CB)
        `CHK({sdo, starts - s0}, {1'b1, 8'h01})
        ext_clk(3); tick(6);
        `CHK({sdo, nbits, starts - s0}, {1'b1, 5'h1B, 8'h01})
        cs_n <= 1'b1; tick(8);
        `CHK(sdo_oe_n, 1'b1)
    end endtask
    // internal clock: pulled-up pin, status poll, then full frame with the kept result
    task s_int; reg [7:0] s0; begin
        h_oe <= 1'b0; pu <= 1'b1; core_done(24'h3C_5A69); tick(4);
        cs_n <= 1'b0; tick(8);
        `CHK({sck_oe_n, sck_o, sdo_oe_n, sdo}, 4'h0)
        tick(100); cs_n <= 1'b1; zap; tick(8);
        `CHK({nbits, sdo_oe_n}, 6'h01)
        cs_n <= 1'b0; tick(2200);
        `CHK(nbits, 5'h00)
        s0 = starts; wait_bits(5'h18); tick(60);
        `CHK(rx, 24'h1E_2D34)
        `CHK({sdo, sck_pin, starts - s0}, {2'h3, 8'h01})
    end endtask
    // flag drop with select low starts a frame; raising select mid-frame restarts conversion
    task s_abort; reg [7:0] s0; begin
        core_done(24'hF0_0F0F); zap; tick(6);
        `CHK(sdo, 1'b0)
        wait_bits(5'h05); s0 = starts; cs_n <= 1'b1; tick(10);
        `CHK({rx[4:0], starts - s0}, {5'h0F, 8'h01})
    end endtask
    initial begin
        tick(3); rst_n <= 1'b1; tick(2); por <= 1'b1; tick(4);
        s_ext; s_int; s_abort; final_report;
    end
endmodule // asrp_port_tb

//--- test/asrp_props.sv
// asrp_props.sv: port-level checker for the serial readout port
// assumes bind onto asrp_port; pins pass two sync flops, so histories span five samples
`timescale 1ns/100ps
module asrp_props #(parameter [15:0] EXT_OSC_PERIOD_CYC = 16'h0064) (
    input wire REF_CLK_I, RST_N_I, CS_N_I, SCK_I, CONV_DONE_I, CONV_START_O,
    input wire SCK_O, SCK_OE_N_O, SCK_PULLUP_O, SDO_O, SDO_OE_N_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_sdo_hiz; CS_N_I [*5] |-> SDO_OE_N_O; endproperty
    a_sdo_hiz: assert property (p_sdo_hiz) else $error("data out driven while deselected");
    property p_sdo_on; $fell(CS_N_I) ##1 !CS_N_I [*5] |-> !SDO_OE_N_O; endproperty
    a_sdo_on: assert property (p_sdo_on) else $error("data out not driven while selected");
    property p_flag; CONV_DONE_I && !CS_N_I && !SDO_OE_N_O |-> ##[1:4] !SDO_O; endproperty
    a_flag: assert property (p_flag) else $error("status flag did not fall");
    property p_start; CONV_START_O |=> !CONV_START_O; endproperty
    a_start: assert property (p_start) else $error("start pulse longer than one cycle");
    property p_pull; !SCK_I [*5] |-> !SCK_PULLUP_O; endproperty
    a_pull: assert property (p_pull) else $error("pull-up on while clock pin low");
    property p_drive; $fell(SCK_OE_N_O) |-> !SCK_O [*8]; endproperty
    a_drive: assert property (p_drive) else $error("generated clock not held low first");
    property p_new_sdo; CONV_START_O && !CS_N_I && !SDO_OE_N_O |-> ##[0:3] SDO_O; endproperty
    a_new_sdo: assert property (p_new_sdo) else $error("data out not high at new conversion");
    property p_sck_rel; CONV_START_O |-> ##[0:3] (SCK_O || SCK_OE_N_O); endproperty
    a_sck_rel: assert property (p_sck_rel) else $error("clock still pulled low at new conversion");
endmodule // asrp_props
bind asrp_port asrp_props #(.EXT_OSC_PERIOD_CYC(EXT_OSC_PERIOD_CYC)) u_props (.*);

//--- verilog/asrp_defs.vh
// asrp_defs.vh: constants for the converter serial readout port
// assumes inclusion by the readout port module only; definitions only
`ifndef ASRP_DEFS_VH
`define ASRP_DEFS_VH
`define ASRP_CLK_MHZ        100
`define ASRP_FRAME_BITS     5'h18
`define ASRP_CNT_W          5
`define ASRP_TEST_DELAY_NS  23000
// 23000 ns at 100 MHz, sized to the delay counter so no bits are dropped
`define ASRP_TEST_DELAY_CYC 16'h08FC
`define ASRP_EXT_DELAY_X10  36
`define ASRP_HALF_SCK_CYC   16'h001A
`define ASRP_DLY_W          16
`define ASRP_ST_CONV        3'h0
`define ASRP_ST_SLEEP       3'h1
`define ASRP_ST_TEST        3'h2
`define ASRP_ST_OUT         3'h3
`define ASRP_ST_DONE        3'h4
`endif

//--- verilog/asrp_port.v
// asrp_port.v: serial result readout and conversion status port of a delta-sigma converter
// assumes a conversion core that pulses a done strobe with a 24-bit frame, and external pad logic
// that resolves the clock and data pins from the output enables (enable low means driving)
`timescale 1ns/100ps
`include "asrp_defs.vh"

module asrp_port #(
    parameter [15:0] EXT_OSC_PERIOD_CYC = 16'h0064  // one external_osc_frequency period in clocks
) (
    // clock, reset, enable
    input  wire        REF_CLK_I,
    input  wire        RST_N_I,
    input  wire        CLK_EN_I,
    // power-on and oscillator selection
    input  wire        POR_DONE_I,
    input  wire        RATE_SELECT_EXT_I,
    // conversion core
    input  wire        CONV_DONE_I,
    input  wire [23:0] CONV_DATA_I,
    output reg         CONV_START_O,
    // pins
    input  wire        CS_N_I,
    input  wire        SCK_I,
    output reg         SCK_O,
    output reg         SCK_OE_N_O,
    output reg         SCK_PULLUP_O,
    output reg         SDO_O,
    output reg         SDO_OE_N_O
);

    // pin synchronisers; first stages feed only second stages
    reg cs_m, cs_s, cs_d, sck_m, sck_s, sck_d;
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cs_m  <= 1'b1;
            cs_s  <= 1'b1;
            cs_d  <= 1'b1;
            sck_m <= 1'b1;
            sck_s <= 1'b1;
            sck_d <= 1'b1;
        end else if (CLK_EN_I) begin
            cs_m  <= CS_N_I;
            cs_s  <= cs_m;
            cs_d  <= cs_s;
            sck_m <= SCK_I;
            sck_s <= sck_m;
            sck_d <= sck_s;
        end
    end

    wire cs_fall  = cs_d & ~cs_s;
    wire cs_rise  = ~cs_d & cs_s;
    wire sck_fall = sck_d & ~sck_s;
    wire sck_rise = ~sck_d & sck_s;

    // test delay in clocks: internal oscillator or 3.6 external periods rounded up
    wire [15:0] ext_dly = (EXT_OSC_PERIOD_CYC * 16'd`ASRP_EXT_DELAY_X10 + 16'd9) / 16'd10;
    wire [15:0] test_dly = RATE_SELECT_EXT_I ? ext_dly : `ASRP_TEST_DELAY_CYC;

    reg  [2:0]  state;
    reg         int_mode;
    reg         por_seen;
    reg         drv_low;     // we drove the clock low when chip select rose
    reg  [23:0] shreg;
    reg  [4:0]  bitcnt;
    reg  [15:0] dly;
    reg         eoc_n;

    // main sequencer
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state        <= `ASRP_ST_CONV;
            int_mode     <= 1'b1;
            por_seen     <= 1'b0;
            drv_low      <= 1'b0;
            shreg        <= 24'h00_0000;
            bitcnt       <= 5'h00;
            dly          <= 16'h0000;
            eoc_n        <= 1'b1;
            CONV_START_O <= 1'b0;
            SCK_O        <= 1'b1;
            SCK_OE_N_O   <= 1'b1;
            SCK_PULLUP_O <= 1'b1;
            SDO_O        <= 1'b1;
            SDO_OE_N_O   <= 1'b1;
        end else if (CLK_EN_I) begin
            CONV_START_O <= 1'b0;
            // mode latch at release of power-on reset, caught by a clocked process
            if (POR_DONE_I && !por_seen) begin
                por_seen <= 1'b1;
                int_mode <= sck_s;
            end
            // pull-up: on at chip select fall, off whenever pin low
            if (!sck_s)
                SCK_PULLUP_O <= 1'b0;
            else if (cs_fall)
                SCK_PULLUP_O <= 1'b1;
            // mode chosen from pin level at chip select fall
            if (cs_fall)
                int_mode <= sck_s;
            // data out driven only while chip select low
            SDO_OE_N_O <= cs_s;
            case (state)
            `ASRP_ST_CONV: begin
                eoc_n <= 1'b1;
                SDO_O <= 1'b1;
                if (CONV_DONE_I) begin
                    shreg <= CONV_DATA_I;
                    eoc_n <= 1'b0;
                    SDO_O <= 1'b0;
                    state <= `ASRP_ST_SLEEP;
                end
            end
            `ASRP_ST_SLEEP: begin
                SDO_O <= 1'b0;
                bitcnt <= 5'h00;
                if (int_mode && !cs_s) begin
                    state <= `ASRP_ST_TEST;
                    dly   <= test_dly;
                end else if (!int_mode && !cs_s && sck_rise) begin
                    state  <= `ASRP_ST_OUT;
                    bitcnt <= 5'h01;
                end
            end
            `ASRP_ST_TEST: begin
                SCK_O      <= 1'b0;
                SCK_OE_N_O <= 1'b0;
                if (cs_s) begin
                    state      <= `ASRP_ST_SLEEP;
                    SCK_OE_N_O <= 1'b1;
                    drv_low    <= 1'b1;
                end else if (dly <= 16'h0001) begin
                    SCK_O  <= 1'b1;
                    state  <= `ASRP_ST_OUT;
                    bitcnt <= 5'h01;
                    dly    <= `ASRP_HALF_SCK_CYC;
                end else
                    dly <= dly - 16'h0001;
            end
            `ASRP_ST_OUT: begin
                if (cs_rise) begin
                    state        <= `ASRP_ST_CONV;
                    CONV_START_O <= 1'b1;
                    SCK_OE_N_O   <= 1'b1;
                    drv_low      <= ~SCK_O;
                end else if (!int_mode) begin
                    if (sck_fall) begin
                        if (bitcnt == `ASRP_FRAME_BITS) begin
                            SDO_O        <= 1'b1;
                            state        <= `ASRP_ST_DONE;
                            CONV_START_O <= 1'b1;
                        end else begin
                            SDO_O <= shreg[23];
                            shreg <= {shreg[22:0], 1'b0};
                        end
                    end else if (sck_rise)
                        bitcnt <= bitcnt + 5'h01;
                end else if (dly <= 16'h0001) begin
                    dly <= `ASRP_HALF_SCK_CYC;
                    // the frame ends with the clock still high, so no 25th rising edge reaches the host
                    if (SCK_O && bitcnt == `ASRP_FRAME_BITS) begin
                        state        <= `ASRP_ST_CONV;
                        SDO_O        <= 1'b1;
                        SCK_OE_N_O   <= 1'b1;
                        CONV_START_O <= 1'b1;
                    end else if (SCK_O) begin
                        SCK_O <= 1'b0;
                        SDO_O <= shreg[23];
                        shreg <= {shreg[22:0], 1'b0};
                    end else begin
                        SCK_O  <= 1'b1;
                        bitcnt <= bitcnt + 5'h01;
                    end
                end else
                    dly <= dly - 16'h0001;
            end
            `ASRP_ST_DONE:
                state <= `ASRP_ST_CONV;
            default:
                state <= `ASRP_ST_CONV;
            endcase
        end
    end

endmodule // asrp_port
